// *** queue_pkg.sv ***
package queue_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] queue_level_threshold_addr = 8'hFC;  // threshold bits 8:1
    localparam logic [7:0] queue_status_high_addr     = 8'hFD;  // level bits 9:2
    localparam logic [7:0] queue_status_low_addr      = 8'hFE;  // flags and level 1:0
    localparam logic [7:0] queue_read_port_addr       = 8'hFF;  // pop port
    localparam logic [7:0] queue_control_addr         = 8'hF0;  // enable and clear
    localparam logic [7:0] irq_status_addr            = 8'hF1;  // sticky events
    localparam logic [7:0] irq_mask_addr              = 8'hF2;  // event mask

    // ==========================================================
    // field positions
    localparam int lost_bit       = 7;   // lost-data flag in status low
    localparam int over_read_bit  = 6;   // over-read flag in status low
    localparam int ctrl_power_bit = 0;   // power_on_enable in control
    localparam int ctrl_clear_bit = 1;   // queue_clear_command, self clearing
    localparam int ev_level_bit   = 0;   // level above threshold event
    localparam int ev_lost_bit    = 1;   // sample dropped event
    localparam int ev_over_bit    = 2;   // empty pop event

    // ==========================================================
    // reset values and sizes
    localparam logic [7:0] threshold_reset = 8'h7F;
    localparam logic [7:0] mask_reset      = 8'h00;
    localparam int         queue_depth     = 512;
    localparam int         level_width     = 10;

endpackage : queue_pkg

// *** queue_store.sv ***
`timescale 1ns/1ps

// ==========================================================
// byte storage: flip-flop array with write and read index
module queue_store
    import queue_pkg::*;
#(
    parameter int depth = 512,
    parameter int aw    = 9
)(
    input  wire logic          clock,
    input  wire logic          write_en,      // store one byte
    input  wire logic [aw-1:0] write_index,   // slot to fill
    input  wire logic [7:0]    write_data,    // byte stored
    input  wire logic [aw-1:0] read_index,    // oldest slot
    output logic      [7:0]    read_data      // oldest byte, combinational
);
    // storage array, no reset needed: level guards every read
    logic [7:0] mem [depth];

    // ==========================================================
    // write port
    always_ff @(posedge clock)
    begin
        if (write_en)
        begin
            mem[write_index] <= write_data;
        end
    end

    assign read_data = mem[read_index];

endmodule : queue_store

// *** sample_queue_readout_status.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - dropped sample sets lost-data flag, bit 7
// - reading beyond fill sets over-read flag, bit 6
// - flags clear only on enable or clear
// - status low: level 1:0, bits 5:2 zero
// - port read returns oldest, pops, lowers level
// - empty read returns zero, flags, no pop
// - single and block reads each pop once
// - 512 bytes; level 9:2 in status high
// - interrupt when level exceeds threshold, reset 7F
module sample_queue_readout_status
    import queue_pkg::*;
#(
    parameter int depth = queue_depth
)(
    input  wire logic       clock,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] address,
    input  wire logic [7:0] write_data,
    input  wire logic       write_strobe,
    input  wire logic       read_strobe,
    output logic      [7:0] read_data,
    // sample producer
    input  wire logic [7:0] sample_data,
    input  wire logic       sample_valid,
    // interrupts
    output logic            queue_level_interrupt,
    output logic            irq
);
    localparam int aw = $clog2(depth);

    // ==========================================================
    // state record
    typedef struct packed {
        logic [aw-1:0]          rd_ptr;      // oldest slot
        logic [aw-1:0]          wr_ptr;      // next free slot
        logic [level_width-1:0] level;       // queue_fill_level 0..512
        logic                   lost;        // lost-data flag
        logic                   over_read;   // over-read flag
        logic                   power_on;    // power_on_enable
        logic [7:0]             threshold;   // queue_level_threshold
        logic [7:0]             ev_status;   // sticky events
        logic [7:0]             ev_mask;     // event mask
        logic                   above_prev;  // for edge of level event
        logic [7:0]             rdata;       // registered read data
    } state_t;

    state_t state;
    state_t next_state;

    logic [7:0] head_byte;  // oldest byte from storage
    logic       push;       // accepted sample
    logic       pop;        // accepted port read
    logic       empty_read; // port read on empty queue
    logic       above;      // level over threshold

    // ==========================================================
    // helpers
    function automatic logic [level_width-1:0] thr_level(input logic [7:0] t);
        // threshold register holds bits 8:1, bit 0 reads as zero
        thr_level = {1'b0, t, 1'b0};
    endfunction : thr_level

    queue_store #(
        .depth (depth),
        .aw    (aw)
    ) store (
        .clock       (clock),
        .write_en    (push),
        .write_index (state.wr_ptr),
        .write_data  (sample_data),
        .read_index  (state.rd_ptr),
        .read_data   (head_byte)
    );

    // ==========================================================
    // decode of this cycle's events
    always_comb
    begin
        pop        = read_strobe && address == queue_read_port_addr && state.level != '0;
        empty_read = read_strobe && address == queue_read_port_addr && state.level == '0;
        // a pop in the same cycle frees a slot, so a full queue can still take a sample
        push       = sample_valid && state.power_on
                     && (state.level != level_width'(depth) || pop);
        above      = state.level > thr_level(state.threshold);
    end

    // ==========================================================
    // next state
    always_comb
    begin
        next_state            = state;
        next_state.above_prev = above;
        next_state.rdata      = 8'h00;

        // pointers and level
        if (push)
        begin
            next_state.wr_ptr = state.wr_ptr + aw'(1);
        end
        if (pop)
        begin
            next_state.rd_ptr = state.rd_ptr + aw'(1);
        end
        case ({push, pop})
            2'b10:   next_state.level = state.level + level_width'(1);
            2'b01:   next_state.level = state.level - level_width'(1);
            default: next_state.level = state.level;
        endcase

        // sticky flags: only enable or clear drops them
        if (sample_valid && !push)
        begin
            next_state.lost = 1'b1;
        end
        if (empty_read)
        begin
            next_state.over_read = 1'b1;
        end

        // event bits: set wins over read clear
        if (read_strobe && address == irq_status_addr)
        begin
            next_state.ev_status = 8'h00;
        end
        if (above && !state.above_prev)
        begin
            next_state.ev_status[ev_level_bit] = 1'b1;
        end
        if (sample_valid && !push)
        begin
            next_state.ev_status[ev_lost_bit] = 1'b1;
        end
        if (empty_read)
        begin
            next_state.ev_status[ev_over_bit] = 1'b1;
        end

        // register writes
        if (write_strobe)
        begin
            case (address)
                queue_level_threshold_addr: next_state.threshold = write_data;
                irq_mask_addr:              next_state.ev_mask   = write_data;
                queue_control_addr:
                begin
                    next_state.power_on = write_data[ctrl_power_bit];
                    // enable assertion or clear command empties queue and flags
                    if (write_data[ctrl_clear_bit] || (write_data[ctrl_power_bit] && !state.power_on))
                    begin
                        // a sample dropped in the very cycle of the clear still counts: set wins
                        // so software never misses a loss that happened while it was clearing
                        next_state.lost      = sample_valid && !push;
                        next_state.over_read = 1'b0;
                        next_state.level     = '0;
                        next_state.rd_ptr    = '0;
                        next_state.wr_ptr    = '0;
                    end
                end
                default: ;
            endcase
        end

        // read data, stands one cycle after the strobe
        if (read_strobe)
        begin
            case (address)
                queue_level_threshold_addr: next_state.rdata = state.threshold;
                queue_status_high_addr:     next_state.rdata = state.level[9:2];
                queue_status_low_addr:      next_state.rdata = {state.lost, state.over_read,
                                                                4'h0, state.level[1:0]};
                queue_read_port_addr:       next_state.rdata = pop ? head_byte : 8'h00;
                queue_control_addr:         next_state.rdata = {7'h00, state.power_on};
                irq_status_addr:            next_state.rdata = state.ev_status;
                irq_mask_addr:              next_state.rdata = state.ev_mask;
                default:                    next_state.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state           <= '0;
            state.threshold <= threshold_reset;
            state.ev_mask   <= mask_reset;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign read_data             = state.rdata;
    assign queue_level_interrupt = state.level > thr_level(state.threshold);
    assign irq                   = |(state.ev_status & state.ev_mask);

    // ==========================================================
    // checks
    sequence empty_port_read;
        read_strobe && address == queue_read_port_addr && state.level == '0;
    endsequence

    sequence pop_read;
        read_strobe && address == queue_read_port_addr && state.level != '0 && !push;
    endsequence

    // sample offered to a full queue with no pop to make room
    sequence full_drop;
        sample_valid && state.level == level_width'(depth) && !pop;
    endsequence

    // read of the event register with no sample offered in the same cycle
    sequence event_read_quiet;
        read_strobe && address == irq_status_addr && !sample_valid;
    endsequence

    // ==========================================================
    // register port timing
    // read data is a one-cycle pulse; anything left over would look like a second answer
    chk_read_idle_zero: assert property (@(posedge clock) disable iff (reset)
        !read_strobe |=> read_data == 8'h00)
        else $error("read data not zero outside answer cycle");

    // upper level bits must match the level at the strobe
    chk_status_high: assert property (@(posedge clock) disable iff (reset)
        read_strobe && address == queue_status_high_addr |=> read_data == $past(state.level[9:2]))
        else $error("status high does not show level 9:2");

    // popped byte is the head at the strobe
    chk_port_data: assert property (@(posedge clock) disable iff (reset)
        pop_read |=> read_data == $past(head_byte))
        else $error("port read did not return oldest byte");

    // ==========================================================
    // producer side
    // with power off nothing is stored, whatever the level
    chk_power_off_drop: assert property (@(posedge clock) disable iff (reset)
        sample_valid && !state.power_on |-> !push)
        else $error("sample stored while power off");

    // a full queue drops and flags the loss
    chk_full_lost: assert property (@(posedge clock) disable iff (reset)
        full_drop and !write_strobe |=> state.lost && state.level == level_width'(depth))
        else $error("full queue did not flag lost sample");

    // ==========================================================
    // clearing and events
    // clear command empties the queue and drops the over-read flag
    chk_clear_flush: assert property (@(posedge clock) disable iff (reset)
        write_strobe && address == queue_control_addr && write_data[ctrl_clear_bit]
            |=> state.level == '0 && !state.over_read)
        else $error("clear command did not flush");

    // level rising over threshold is latched as an event
    chk_level_event: assert property (@(posedge clock) disable iff (reset)
        above && !state.above_prev |=> state.ev_status[ev_level_bit])
        else $error("level event not latched");

    // reading the event register clears bits that no event sets again
    chk_event_clear: assert property (@(posedge clock) disable iff (reset)
        event_read_quiet |=> !state.ev_status[ev_over_bit] && !state.ev_status[ev_lost_bit])
        else $error("event status not cleared by read");

    chk_lost_sets: assert property (@(posedge clock) disable iff (reset)
        sample_valid && !push && !write_strobe |=> state.lost)
        else $error("lost flag not set on dropped sample");

    chk_over_read_sets: assert property (@(posedge clock) disable iff (reset)
        empty_port_read and !write_strobe |=> state.over_read)
        else $error("over-read flag not set");

    chk_flags_hold: assert property (@(posedge clock) disable iff (reset)
        state.lost && !write_strobe |=> state.lost)
        else $error("lost flag dropped without clear");

    chk_status_low_fmt: assert property (@(posedge clock) disable iff (reset)
        read_strobe && address == queue_status_low_addr |=>
            read_data[5:2] == 4'h0 && read_data[1:0] == $past(state.level[1:0]))
        else $error("status low format wrong");

    chk_pop_level: assert property (@(posedge clock) disable iff (reset)
        pop_read and !write_strobe |=> state.level == $past(state.level) - level_width'(1))
        else $error("pop did not lower level");

    chk_empty_zero: assert property (@(posedge clock) disable iff (reset)
        empty_port_read and !sample_valid and !write_strobe |=>
            read_data == 8'h00 && $stable(state.rd_ptr) && state.level == '0)
        else $error("empty read misbehaved");

    chk_block_pops: assert property (@(posedge clock) disable iff (reset)
        pop_read ##1 (pop_read and !write_strobe) |=> state.rd_ptr == $past(state.rd_ptr, 2) + aw'(2))
        else $error("block read did not pop each byte");

    chk_level_bound: assert property (@(posedge clock) disable iff (reset)
        state.level <= level_width'(depth))
        else $error("level beyond capacity");

    chk_level_irq: assert property (@(posedge clock) disable iff (reset)
        queue_level_interrupt == (state.level > {1'b0, state.threshold, 1'b0}))
        else $error("level interrupt wrong");

    chk_over_persist: assert property (@(posedge clock) disable iff (reset)
        state.over_read && read_strobe && !write_strobe |=> state.over_read)
        else $error("over-read flag lost on read");

endmodule : sample_queue_readout_status

// *** host_model.sv ***
`timescale 1ns/1ps

// ==========================================================
// host on the register port; the bench calls its tasks
module host_model
    import queue_pkg::*;
(
    input  wire logic       clock,
    output logic      [7:0] address,
    output logic      [7:0] write_data,
    output logic            write_strobe,
    output logic            read_strobe,
    input  wire logic [7:0] read_data
);
    // idle bus at time zero
    initial
    begin
        address      = 8'h00;
        write_data   = 8'h00;
        write_strobe = 1'b0;
        read_strobe  = 1'b0;
    end

    // ==========================================================
    // one write; data inverted after, so stale data never looks good
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address      <= a;
        write_data   <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        write_data   <= ~d;
    endtask : wr

    // one read; answer taken just after the edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        address     <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 d = read_data;
    endtask : rd

    // block read: strobe held, one pop per cycle
    task automatic rd_block(input int n, output logic [7:0] q [$]);
        q = {};
        @(posedge clock);
        address     <= queue_read_port_addr;
        read_strobe <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock);
            if (i == n - 1) read_strobe <= 1'b0;
            #1 q.push_back(read_data);
        end
    endtask : rd_block

    // high level byte first, then flags and low bits
    task automatic level(output logic [7:0] hi, output logic [7:0] lo);
        rd(queue_status_high_addr, hi);
        rd(queue_status_low_addr, lo);
    endtask : level
endmodule : host_model

// *** tb.sv ***
`timescale 1ns/1ps

// ==========================================================
// self-checking bench for the queue read-out block
module tb;
    import queue_pkg::*;
    logic       clock;
    logic       reset;
    logic [7:0] address, write_data, read_data, sample_data, v, w;
    logic       write_strobe, read_strobe, sample_valid, queue_level_interrupt, irq;
    logic [7:0] q [$];
    int         n_fail = 0, comparisons = 0, cycles = 0;

    // 250 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    sample_queue_readout_status #(.depth(queue_depth)) i_dut (.clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .queue_level_interrupt(queue_level_interrupt), .irq(irq));
    host_model i_host (.clock(clock), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data));

    // ==========================================================
    // compare tasks and verdict
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // hang guard, far above the several hundred cycles needed
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // ==========================================================
    // producer side: back-to-back samples of a known pattern
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 5 + 3);
    endfunction : pat
    task automatic fill(input int n);
        @(posedge clock);
        sample_valid <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            sample_data <= pat(i);
            @(posedge clock);
        end
        sample_valid <= 1'b0;
    endtask : fill
    task automatic settle;
        @(posedge clock);
        #1;
    endtask : settle

    // ==========================================================
    // scenarios
    task automatic t_reset;
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h00, "status low reset");
        i_host.rd(queue_level_threshold_addr, v); chk8(v, threshold_reset, "threshold reset");
        i_host.rd(irq_mask_addr, v); chk8(v, mask_reset, "mask reset");
        i_host.rd(8'h10, v); chk8(v, 8'h00, "unmapped read");
        chk1(irq, 1'b0, "irq reset");
        chk1(queue_level_interrupt, 1'b0, "level irq reset");
    endtask : t_reset
    task automatic t_lost; // power still off, sample must drop
        fill(1);
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h80, "lost flag");
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h80, "lost flag kept");
        i_host.rd(irq_status_addr, v); chk8(v, 8'h02, "lost event");
        i_host.wr(queue_control_addr, 8'h01);
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h00, "power on clears");
    endtask : t_lost
    task automatic t_drain;
        fill(6);
        i_host.level(v, w); chk8(v, 8'h01, "level high 6"); chk8(w, 8'h02, "level low 6");
        i_host.rd(queue_read_port_addr, v); chk8(v, pat(0), "oldest byte");
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h01, "level after pop");
        i_host.rd_block(5, q);
        for (int i = 0; i < 5; i++) chk8(q[i], pat(i + 1), "block byte");
        i_host.level(v, w); chk8(v, 8'h00, "drained high"); chk8(w, 8'h00, "drained low");
    endtask : t_drain
    task automatic t_empty;
        i_host.rd(queue_read_port_addr, v); chk8(v, 8'h00, "empty read zero");
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h40, "over-read flag");
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h40, "over-read kept");
        i_host.rd(irq_status_addr, v); chk8(v, 8'h04, "empty event");
        fill(1);
        i_host.rd(queue_read_port_addr, v); chk8(v, pat(0), "no pop on empty");
        i_host.wr(queue_control_addr, 8'h03);
        i_host.rd(queue_status_low_addr, v); chk8(v, 8'h00, "clear command");
    endtask : t_empty
    task automatic t_full; // threshold 7F: interrupt above 254 bytes
        fill(254); settle(); chk1(queue_level_interrupt, 1'b0, "level 254");
        fill(1); settle(); chk1(queue_level_interrupt, 1'b1, "level 255");
        chk1(irq, 1'b0, "irq masked");
        fill(258);
        i_host.level(v, w); chk8(v, 8'h80, "full high"); chk8(w, 8'h80, "full low and lost");
        i_host.wr(irq_mask_addr, 8'h07); settle(); chk1(irq, 1'b1, "irq unmasked");
        i_host.rd(irq_status_addr, v); chk8(v, 8'h03, "level and lost events");
        settle(); chk1(irq, 1'b0, "irq after status read");
        i_host.wr(queue_control_addr, 8'h03);
        i_host.level(v, w); chk8(v, 8'h00, "flushed high"); chk8(w, 8'h00, "flushed low");
        chk1(queue_level_interrupt, 1'b0, "level irq flushed");
    endtask : t_full

    // ==========================================================
    // main sequence
    initial
    begin
        reset        = 1'b1;
        sample_valid = 1'b0;
        sample_data  = 8'h00;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_lost();
        t_drain();
        t_empty();
        t_full();
        end_of_test();
    end
endmodule : tb
